// ---- pkg/io_core_pkg.sv ----
// Constants and types shared by the I/O microprocessor core.
`default_nettype none
package io_core_pkg;
  // Clock and time-state timing.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned STATE_TIME_PS = 60000;
  localparam int unsigned RAM_EXTRA_PS = 30000;
  localparam logic [4:0] STATE_CYC = 5'((STATE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [4:0] RAM_EXTRA_CYC = 5'((RAM_EXTRA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [4:0] BRANCH_SECOND_CYC = 5'(2 * STATE_CYC);
  localparam logic [4:0] RAM_THIRD_CYC = 5'(STATE_CYC + RAM_EXTRA_CYC);

  // APB register byte offsets.
  localparam logic [11:0] OFS_CSR_LOW = 12'h000;
  localparam logic [11:0] OFS_CSR_HIGH = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_STATE = 12'h00C;

  // Field positions and reset values.
  localparam int unsigned BYPASS_BIT = 1;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [15:0] MIR_RESET = 16'h0000;
  localparam logic [3:0] RAM_DMA_CTRL = 4'h8;
  localparam logic [3:0] RAM_IRQ_CTRL = 4'h9;
  localparam logic [3:0] RAM_PAGE_SHADOW = 4'hD;
  localparam int unsigned DMA_START_BIT = 0;
  localparam int unsigned DMA_NOT_LAST_BIT = 1;
  localparam int unsigned IRQ_REQ_BIT = 0;
  localparam int unsigned IRQ_VEC_BIT = 1;

  typedef enum logic [1:0] {ts_first = 2'b00, ts_second = 2'b01, ts_third = 2'b10} ts_t;

  typedef enum logic [2:0] {
    src_imm = 3'b000, src_brg = 3'b001, src_dmem = 3'b010, src_ram = 3'b011,
    src_pc = 3'b100, src_mar = 3'b101, src_line = 3'b110, src_store = 3'b111
  } src_t;

  typedef enum logic [2:0] {
    dst_none = 3'b000, dst_scratch = 3'b001, dst_brg_load = 3'b010, dst_brg_shift = 3'b011,
    dst_dmem = 3'b100, dst_mar_low = 3'b101, dst_mar_high = 3'b110, dst_out = 3'b111
  } dest_t;

  typedef enum logic [3:0] {
    alu_add = 4'h0, alu_sub = 4'h1, alu_adc = 4'h2, alu_sbc = 4'h3,
    alu_and = 4'h4, alu_or = 4'h5, alu_xor = 4'h6, alu_b = 4'h7,
    alu_a = 4'h8, alu_not_b = 4'h9, alu_inc_a = 4'hA, alu_inc_b = 4'hB,
    alu_dec_a = 4'hC, alu_a_and_not_b = 4'hD, alu_two_a = 4'hE, alu_zero = 4'hF
  } alu_op_t;
endpackage : io_core_pkg
`default_nettype wire

// ---- hdl/io_microprocessor_core.sv ----
// I/O microprocessor core: sequencer, datapath, shared RAM, APB slave, DMA and interrupt requests.
`timescale 1ns/1ps
`default_nettype none
module io_microprocessor_core #(
  parameter logic [2:0] IRQ_LEVEL = 3'h5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [13:0] store_addr,
  input wire logic [15:0] store_data,
  input wire logic [7:0] line_in,
  output logic dma_request,
  input wire logic dma_grant,
  input wire logic dma_done,
  output logic bus_master,
  output logic irq_request,
  input wire logic irq_ack,
  input wire logic [5:0] vector_base,
  output logic [8:0] irq_vector,
  output logic [2:0] irq_priority,
  output logic [2:0] time_state
);
  // Source decode: class, bit 7 and bit 4 select the B source and the move flag.
  function automatic logic [3:0] source_decode(input logic [4:0] idx);
    source_decode = {idx[4:3] != 2'b00, idx[2:0]};
  endfunction : source_decode

  // Function decode: top index bit forces carry capture, the rest select the operation.
  function automatic logic [4:0] function_decode(input logic [4:0] idx);
    function_decode = {idx[4], idx[3:0]};
  endfunction : function_decode

  function automatic logic [8:0] alu_calc(input io_core_pkg::alu_op_t op, input logic [7:0] a,
                                          input logic [7:0] b, input logic cin);
    case (op)
      io_core_pkg::alu_add: alu_calc = {1'b0, a} + {1'b0, b};
      io_core_pkg::alu_sub: alu_calc = {1'b0, a} - {1'b0, b};
      io_core_pkg::alu_adc: alu_calc = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      io_core_pkg::alu_sbc: alu_calc = {1'b0, a} - {1'b0, b} - {8'h00, ~cin};
      io_core_pkg::alu_and: alu_calc = {1'b0, a & b};
      io_core_pkg::alu_or: alu_calc = {1'b0, a | b};
      io_core_pkg::alu_xor: alu_calc = {1'b0, a ^ b};
      io_core_pkg::alu_b: alu_calc = {1'b0, b};
      io_core_pkg::alu_a: alu_calc = {1'b0, a};
      io_core_pkg::alu_not_b: alu_calc = {1'b0, ~b};
      io_core_pkg::alu_inc_a: alu_calc = {1'b0, a} + 9'h001;
      io_core_pkg::alu_inc_b: alu_calc = {1'b0, b} + 9'h001;
      io_core_pkg::alu_dec_a: alu_calc = {1'b0, a} - 9'h001;
      io_core_pkg::alu_a_and_not_b: alu_calc = {1'b0, a & ~b};
      io_core_pkg::alu_two_a: alu_calc = {a, 1'b0};
      default: alu_calc = 9'h000;
    endcase
  endfunction : alu_calc

  io_core_pkg::ts_t ts;
  io_core_pkg::ts_t next_ts;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [15:0] instr_latch;
  logic [15:0] maint_instr_reg;
  logic [7:0] ctrl1;
  logic [11:0] mem_addr_reg;
  logic [7:0] branch_shift_reg;
  logic [5:0] page_shadow_reg;
  logic [7:0] buffered_alu_out;
  logic carry_flag;
  logic equal_flag;
  logic cap_carry;
  logic cap_equal;
  logic [7:0] data_mem [0:4095];
  logic [7:0] scratch_file [0:15];
  logic [7:0] shared_port_ram [0:15];

  // Instruction decode.
  wire logic store_bypass_select = ctrl1[io_core_pkg::BYPASS_BIT];
  wire logic [15:0] fetch_word = (store_bypass_select ? 16'h0000 : store_data)
                                 | (store_bypass_select ? maint_instr_reg : 16'h0000);
  wire logic [3:0] src_word = source_decode({instr_latch[15:13], instr_latch[7], instr_latch[4]});
  wire logic is_move = src_word[3];
  wire logic is_branch = ~is_move;
  wire io_core_pkg::src_t b_sel = io_core_pkg::src_t'(src_word[2:0]);
  wire io_core_pkg::dest_t dest = io_core_pkg::dest_t'(instr_latch[12:10]);
  wire logic dest_out = is_move && dest == io_core_pkg::dst_out;
  wire logic [4:0] fn_word = function_decode({instr_latch[12], instr_latch[9:8], instr_latch[6:5]});
  wire io_core_pkg::alu_op_t alu_op = io_core_pkg::alu_op_t'(fn_word[3:0]);

  // Operand selection and ALU.
  wire logic [3:0] sp_addr = dest_out ? 4'h0 : instr_latch[3:0];
  wire logic [3:0] ram_addr = instr_latch[3:0];
  wire logic [7:0] a_val = scratch_file[sp_addr];
  wire logic [7:0] ram_port_b = shared_port_ram[ram_addr];
  logic [7:0] b_val;
  always_comb
  begin
    unique case (b_sel)
      io_core_pkg::src_imm: b_val = instr_latch[7:0];
      io_core_pkg::src_brg: b_val = branch_shift_reg;
      io_core_pkg::src_dmem: b_val = data_mem[mem_addr_reg];
      io_core_pkg::src_ram: b_val = ram_port_b;
      io_core_pkg::src_pc: b_val = store_addr[7:0];
      io_core_pkg::src_mar: b_val = mem_addr_reg[7:0];
      io_core_pkg::src_line: b_val = line_in;
      io_core_pkg::src_store: b_val = store_data[7:0];
    endcase
  end
  wire logic [8:0] alu_res = alu_calc(alu_op, a_val, b_val, carry_flag);

  // Branch condition multiplexer.
  logic cond_hit;
  always_comb
  begin
    unique case (instr_latch[10:8])
      3'h0: cond_hit = 1'b1;
      3'h1: cond_hit = carry_flag;
      3'h2: cond_hit = ~carry_flag;
      3'h3: cond_hit = equal_flag;
      3'h4: cond_hit = ~equal_flag;
      3'h5: cond_hit = branch_shift_reg[0];
      3'h6: cond_hit = branch_shift_reg[7];
      3'h7: cond_hit = bus_master;
    endcase
  end
  wire logic branch_true = is_branch && cond_hit;
  wire logic ram_access = is_move && (b_sel == io_core_pkg::src_ram || dest_out);

  // APB decode.
  wire logic host_ram_hit = paddr == io_core_pkg::OFS_CSR_LOW || paddr == io_core_pkg::OFS_CSR_HIGH;
  wire logic mapped = host_ram_hit || paddr == io_core_pkg::OFS_STATUS || paddr == io_core_pkg::OFS_STATE;
  wire logic host_wr_busy = psel && penable && pwrite && host_ram_hit;
  wire logic apb_fire = psel && penable && pready;
  wire logic host_wr = apb_fire && pwrite && !pslverr;
  wire logic [3:0] host_base = (paddr == io_core_pkg::OFS_CSR_HIGH) ? 4'h4 : 4'h0;
  logic [31:0] next_prdata;
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (host_ram_hit)
    begin
      next_prdata = {shared_port_ram[host_base + 4'h3], shared_port_ram[host_base + 4'h2],
                     shared_port_ram[host_base + 4'h1], shared_port_ram[host_base]};
    end
    else if (paddr == io_core_pkg::OFS_STATUS)
    begin
      next_prdata = {2'h0, store_addr, 4'h0, mem_addr_reg};
    end
    else if (paddr == io_core_pkg::OFS_STATE)
    begin
      next_prdata = {24'h000000, irq_request, bus_master, dma_request, carry_flag, equal_flag,
                     store_bypass_select, ts};
    end
  end

  // Time-state sequencer.
  wire logic [4:0] state_len = (ts == io_core_pkg::ts_second && branch_true) ? io_core_pkg::BRANCH_SECOND_CYC
                             : (ts == io_core_pkg::ts_third && ram_access) ? io_core_pkg::RAM_THIRD_CYC
                             : io_core_pkg::STATE_CYC;
  wire logic state_end = cnt == state_len - 5'h01;
  wire logic stall = ts == io_core_pkg::ts_second && ram_access && host_wr_busy;
  wire logic advance = state_end && !stall;
  wire logic fetch = ts == io_core_pkg::ts_first && cnt == 5'h00;
  wire logic third_start = ts == io_core_pkg::ts_second && advance;
  wire logic third_end = ts == io_core_pkg::ts_third && advance;
  wire logic proc_ram_wr = third_start && dest_out;
  wire logic [7:0] alu_byte = alu_res[7:0];
  always_comb
  begin
    unique case (ts)
      io_core_pkg::ts_first: next_ts = advance ? io_core_pkg::ts_second : ts;
      io_core_pkg::ts_second: next_ts = advance ? io_core_pkg::ts_third : ts;
      io_core_pkg::ts_third: next_ts = advance ? io_core_pkg::ts_first : ts;
      default: next_ts = io_core_pkg::ts_first;
    endcase
  end
  assign next_cnt = advance ? 5'h00 : (state_end ? cnt : cnt + 5'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ts <= io_core_pkg::ts_first;
      cnt <= 5'h00;
      time_state <= 3'h1;
    end
    else
    begin
      ts <= next_ts;
      cnt <= next_cnt;
      time_state <= 3'h1 << next_ts;
    end
  end

  // Instruction fetch, program counter and datapath registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_latch <= 16'h0000;
      store_addr <= 14'h0000;
      mem_addr_reg <= 12'h000;
      branch_shift_reg <= 8'h00;
      page_shadow_reg <= 6'h00;
      buffered_alu_out <= 8'h00;
      cap_carry <= 1'b0;
      cap_equal <= 1'b0;
      carry_flag <= 1'b0;
      equal_flag <= 1'b0;
    end
    else
    begin
      if (fetch)
        instr_latch <= fetch_word;
      if (ts == io_core_pkg::ts_second && cnt == 5'h00 && !branch_true)
        store_addr <= store_addr + 14'h0001;
      if (third_start)
      begin
        buffered_alu_out <= alu_byte;
        cap_carry <= alu_res[8];
        cap_equal <= a_val == b_val;
      end
      if (proc_ram_wr && ram_addr == io_core_pkg::RAM_PAGE_SHADOW)
        page_shadow_reg <= alu_byte[5:0];
      if (third_end)
      begin
        if (branch_true && instr_latch[10:8] == 3'h0)
          store_addr <= {page_shadow_reg, buffered_alu_out};
        else if (branch_true)
          store_addr <= {store_addr[13:10], instr_latch[12:11], buffered_alu_out};
        if (is_move || fn_word[4])
          carry_flag <= cap_carry;
        if (is_move)
          equal_flag <= cap_equal;
        if (is_move && dest == io_core_pkg::dst_brg_load)
          branch_shift_reg <= buffered_alu_out;
        if (is_move && dest == io_core_pkg::dst_brg_shift)
          branch_shift_reg <= {buffered_alu_out[0], branch_shift_reg[7:1]};
        if (is_move && dest == io_core_pkg::dst_mar_low)
          mem_addr_reg[7:0] <= buffered_alu_out;
        if (is_move && dest == io_core_pkg::dst_mar_high)
          mem_addr_reg[11:8] <= buffered_alu_out[3:0];
      end
    end
  end

  // Memories without reset; the shared RAM port A serves both processor and host.
  always_ff @(posedge pclk)
  begin
    if (third_end && is_move && dest == io_core_pkg::dst_dmem)
      data_mem[mem_addr_reg] <= buffered_alu_out;
    if (third_end && is_move && dest == io_core_pkg::dst_scratch)
      scratch_file[instr_latch[3:0]] <= buffered_alu_out;
    if (proc_ram_wr)
      shared_port_ram[ram_addr] <= alu_byte;
    for (int i = 0; i < 4; i++)
    begin
      if (host_wr && host_ram_hit && pstrb[i])
        shared_port_ram[host_base + 4'(i)] <= pwdata[8 * i +: 8];
    end
  end

  // Host control byte 1 and maintenance instruction register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1 <= io_core_pkg::CTRL1_RESET;
      maint_instr_reg <= io_core_pkg::MIR_RESET;
    end
    else if (host_wr)
    begin
      if (paddr == io_core_pkg::OFS_CSR_LOW && pstrb[1])
        ctrl1 <= pwdata[15:8];
      if (paddr == io_core_pkg::OFS_CSR_HIGH && pstrb[2])
        maint_instr_reg[7:0] <= pwdata[23:16];
      if (paddr == io_core_pkg::OFS_CSR_HIGH && pstrb[3])
        maint_instr_reg[15:8] <= pwdata[31:24];
    end
  end

  // APB answer: one wait state, registered data and error.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        pslverr <= !mapped;
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // DMA request, bus mastership and interrupt request.
  wire logic dma_start = proc_ram_wr && ram_addr == io_core_pkg::RAM_DMA_CTRL && alu_byte[io_core_pkg::DMA_START_BIT];
  wire logic not_last = shared_port_ram[io_core_pkg::RAM_DMA_CTRL][io_core_pkg::DMA_NOT_LAST_BIT];
  wire logic irq_start = proc_ram_wr && ram_addr == io_core_pkg::RAM_IRQ_CTRL && alu_byte[io_core_pkg::IRQ_REQ_BIT];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_request <= 1'b0;
      bus_master <= 1'b0;
      irq_request <= 1'b0;
      irq_vector <= 9'h000;
      irq_priority <= 3'h5;
    end
    else
    begin
      irq_priority <= IRQ_LEVEL;
      if (dma_start && !bus_master)
        dma_request <= 1'b1;
      else if (dma_grant)
        dma_request <= 1'b0;
      if (dma_request && dma_grant)
        bus_master <= 1'b1;
      else if (dma_done && !not_last)
        bus_master <= 1'b0;
      if (irq_start)
      begin
        irq_request <= 1'b1;
        irq_vector <= {vector_base, alu_byte[io_core_pkg::IRQ_VEC_BIT], 2'b00};
      end
      else if (irq_ack)
        irq_request <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_onehot_state;
    $onehot(time_state) && ts != 2'b11;
  endproperty
  a_onehot_state: assert property (p_onehot_state) else $error("time state not one-hot");

  property p_first_len;
    (ts == io_core_pkg::ts_first && advance) |-> cnt == io_core_pkg::STATE_CYC - 5'h01;
  endproperty
  a_first_len: assert property (p_first_len) else $error("first state length wrong");

  property p_branch_len;
    (third_start && branch_true) |-> cnt == io_core_pkg::BRANCH_SECOND_CYC - 5'h01;
  endproperty
  a_branch_len: assert property (p_branch_len) else $error("true branch second state wrong");

  property p_ram_len;
    (third_end && ram_access) |-> cnt == io_core_pkg::RAM_THIRD_CYC - 5'h01;
  endproperty
  a_ram_len: assert property (p_ram_len) else $error("shared RAM move third state wrong");

  property p_stall;
    (ts == io_core_pkg::ts_second && state_end && stall) |=> ts == io_core_pkg::ts_second;
  endproperty
  a_stall: assert property (p_stall) else $error("sequencer ran through a host write");

  property p_pc_inc;
    (ts == io_core_pkg::ts_second && cnt == 5'h00 && !branch_true) |=> store_addr == $past(store_addr) + 14'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("counter did not increment");

  property p_page_load;
    (third_end && branch_true && instr_latch[10:8] != 3'h0)
      |=> store_addr == {$past(store_addr[13:10]), $past(instr_latch[12:11]), $past(buffered_alu_out)};
  endproperty
  a_page_load: assert property (p_page_load) else $error("branch page load wrong");

  property p_brg_shift;
    (third_end && is_move && dest == io_core_pkg::dst_brg_shift)
      |=> branch_shift_reg == {$past(buffered_alu_out[0]), $past(branch_shift_reg[7:1])};
  endproperty
  a_brg_shift: assert property (p_brg_shift) else $error("shift right wrong");

  property p_mir_load;
    (host_wr && paddr == io_core_pkg::OFS_CSR_HIGH && pstrb[3:2] == 2'b11) |=> maint_instr_reg == $past(pwdata[31:16]);
  endproperty
  a_mir_load: assert property (p_mir_load) else $error("maintenance register not loaded");

  property p_bypass_fetch;
    (fetch && store_bypass_select) |=> instr_latch == $past(maint_instr_reg);
  endproperty
  a_bypass_fetch: assert property (p_bypass_fetch) else $error("bypass fetch wrong");

  property p_dma_grant;
    (dma_request && dma_grant) |=> bus_master && !dma_request;
  endproperty
  a_dma_grant: assert property (p_dma_grant) else $error("grant did not give mastership");

  property p_vector;
    $rose(irq_request) |-> irq_vector[1:0] == 2'b00 && irq_vector[8:3] == $past(vector_base);
  endproperty
  a_vector: assert property (p_vector) else $error("vector not on XX0 or XX4");
endmodule : io_microprocessor_core
`default_nettype wire

// ---- verif/io_core_far_side.sv ----
// Far-side model: control store contents and a bus grant responder.
`timescale 1ns/1ps
`default_nettype none
module io_core_far_side (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [13:0] store_addr,
  output logic [15:0] store_data,
  input wire logic dma_request,
  output logic dma_grant,
  output logic dma_done
);
  // Word 0 branches to word 0DF on carry clear, which holds after reset.
  // Every other word moves immediate 60 into scratch location 0, so carry stays known.
  assign store_data = (store_addr == 14'h0000) ? 16'h0220 : 16'h4560;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_grant <= 1'b0;
      dma_done <= 1'b0;
    end
    else
    begin
      dma_grant <= dma_request & ~dma_grant;
      dma_done <= dma_grant;
    end
  end
endmodule : io_core_far_side
`default_nettype wire

// ---- verif/io_microprocessor_core_tb_top.sv ----
// Self-checking testbench of the I/O microprocessor core.
`timescale 1ns/1ps
`default_nettype none
module io_microprocessor_core_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] line_in = 8'h00;
  logic [5:0] vector_base = 6'h2A;
  logic irq_ack = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [13:0] store_addr;
  logic [15:0] store_data;
  logic dma_request;
  logic dma_grant;
  logic dma_done;
  logic [2:0] irq_priority;
  logic [2:0] time_state;
  logic bus_master;
  logic irq_request;
  logic [8:0] irq_vector;
  logic saw_master = 1'b0;
  logic [31:0] seed = 32'd37;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  io_microprocessor_core DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .store_addr(store_addr), .store_data(store_data), .line_in(line_in), .dma_request(dma_request),
    .dma_grant(dma_grant), .dma_done(dma_done), .bus_master(bus_master), .irq_request(irq_request),
    .irq_ack(irq_ack), .vector_base(vector_base), .irq_vector(irq_vector), .irq_priority(irq_priority),
    .time_state(time_state));
  io_core_far_side far (.pclk(pclk), .presetn(presetn), .store_addr(store_addr), .store_data(store_data),
    .dma_request(dma_request), .dma_grant(dma_grant), .dma_done(dma_done));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_ts(input logic [2:0] v);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (time_state !== v && n < 200);
  endtask : wait_ts
  // Length of one time state in clock cycles.
  task automatic ts_len(input logic [2:0] v, output int len);
    wait_ts(v);
    len = 0;
    while (time_state === v && len < 100)
    begin
      @(negedge pclk);
      len++;
    end
  endtask : ts_len
  // Lets an instruction fetched after the call run through its third state.
  task automatic run_instr();
    wait_ts(3'b100);
    wait_ts(3'b001);
    wait_ts(3'b100);
    wait_ts(3'b001);
  endtask : run_instr
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    line_in <= 8'(xs());
    if (bus_master === 1'b1)
      saw_master = 1'b1;
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  initial
  begin
    logic [31:0] r;
    logic [31:0] d;
    logic e;
    logic [13:0] a;
    int len;
    repeat (3) @(posedge pclk);
    chk(32'(time_state), 32'h1);
    chk(32'(irq_priority), 32'h5);
    presetn <= 1'b1;
    ts_len(3'b010, len);
    chk(32'(len), 32'd24);
    wait_ts(3'b001);
    chk(32'(store_addr), 32'h00DF);
    a = store_addr;
    ts_len(3'b010, len);
    chk(32'(len), 32'd12);
    wait_ts(3'b001);
    chk(32'(store_addr), 32'(a + 14'h1));
    for (int i = 0; i < 4; i++)
    begin
      d = xs() & 32'hFFFFFDFF;
      apb(1'b1, 12'h000 + 12'(4 * (i % 2)), d, r, e);
      apb(1'b0, 12'h000 + 12'(4 * (i % 2)), 32'h0, r, e);
      chk(r, d);
      chk(32'(e), 32'h0);
    end
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    d = xs();
    apb(1'b1, 12'h004, {16'h0220, d[15:0]}, r, e);
    apb(1'b1, 12'h000, 32'h00000200, r, e);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    chk(32'(r[2]), 32'h1);
    wait_ts(3'b100);
    wait_ts(3'b001);
    ts_len(3'b010, len);
    chk(32'(len), 32'd24);
    // Maintenance move of immediate 65 into shared RAM byte 5 stretches the third state.
    apb(1'b1, 12'h004, {16'h5D65, d[15:0]}, r, e);
    wait_ts(3'b100);
    wait_ts(3'b001);
    ts_len(3'b100, len);
    chk(32'(len), 32'd18);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk(32'(r[15:8]), 32'h65);
    // Move of 69 into RAM byte 9 raises the interrupt on the vector ending in zero.
    apb(1'b1, 12'h004, {16'h5D69, d[15:0]}, r, e);
    run_instr();
    chk(32'(irq_request), 32'h1);
    chk(32'(irq_vector), 32'({vector_base, 3'b000}));
    @(posedge pclk);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    @(negedge pclk);
    chk(32'(irq_request), 32'h0);
    // Move of 68 plus one into RAM byte 8 starts a single transfer.
    apb(1'b1, 12'h004, {16'h5E68, d[15:0]}, r, e);
    run_instr();
    chk(32'(saw_master), 32'h1);
    chk(32'(dma_request), 32'h0);
    complete_run();
  end
endmodule : io_microprocessor_core_tb_top
`default_nettype wire
